// ===== verilog/ewac_core.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - select low floats outputs, blocks all operations
// - mode 0/1 erases addressed word
// - mode one high reads on strobe pulse
// - read word held until deselect or mode change
// - mode 0/0 writes data without strobe
// - erase and write need no strobe
// - five-bit address selects one of 32 words
// - data pins bidirectional, host drives in write only
module ewac_core #(
  parameter int unsigned PROG_CYC = ewac_pkg::EWAC_PROG_STD_CYC
) (
  input  wire logic                             mclk,
  input  wire logic                             nrst,
  input  wire ewac_pkg::ewac_ctl_t              ctl,
  input  wire logic [ewac_pkg::EWAC_DATA_W-1:0] data_lines_in,
  output var  logic [ewac_pkg::EWAC_DATA_W-1:0] data_lines_out,
  output var  logic [ewac_pkg::EWAC_DATA_W-1:0] data_lines_oe,
  output var  logic                             busy,
  output var  logic                             power_down
);
  import ewac_pkg::*;

  // =====================================================
  // input synchronisers
  localparam int unsigned CW = $bits(ewac_ctl_t);
  ewac_ctl_t              c;
  logic [EWAC_DATA_W-1:0] din;
  logic [CW-1:0]          c_raw;

  ewac_sync #(.W(CW)) u_sync_ctl (
    .mclk (mclk),
    .nrst (nrst),
    .d    (ctl),
    .q    (c_raw)
  );
  ewac_sync #(.W(EWAC_DATA_W)) u_sync_dat (
    .mclk (mclk),
    .nrst (nrst),
    .d    (data_lines_in),
    .q    (din)
  );
  assign c = ewac_ctl_t'(c_raw);

  // =====================================================
  // edge detection; operations are armed by edges, like the dynamic cells
  ewac_ctl_t   prev_reg;
  logic [1:0]  mode;
  logic        strobe_rise;
  logic        ctl_edge;
  assign mode        = {c.mode_line_one, c.mode_line_two};
  assign strobe_rise = c.strobe & ~prev_reg.strobe;
  assign ctl_edge    = (c.sel != prev_reg.sel)
                     | (c.mode_line_one != prev_reg.mode_line_one)
                     | (c.mode_line_two != prev_reg.mode_line_two)
                     | strobe_rise;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= c;
    end
  end

  // =====================================================
  // storage and state
  logic [EWAC_DATA_W-1:0] word_q [EWAC_WORDS];
  ewac_state_t            state_reg;
  logic [31:0]            cnt_reg;
  logic                   armed_reg;
  logic                   done;
  logic                   commit;
  logic                   erase_commit;
  logic                   write_commit;
  logic                   read_fire;
  // the timer parks one past the last cycle, so a long hold commits exactly once
  assign done         = (cnt_reg >= PROG_CYC);
  assign commit       = c.sel && (cnt_reg == PROG_CYC - 1);
  assign erase_commit = commit && (state_reg == EWAC_ERASE);
  assign write_commit = commit && (state_reg == EWAC_WRITE);
  // a strobe pulse reads in idle and again while a read is held
  assign read_fire    = c.sel && c.mode_line_one && strobe_rise
                      && (state_reg == EWAC_IDLE || state_reg == EWAC_READ);

  // =====================================================
  // arming: a new operation needs an edge on a control line
  // without it a held mode would program the same word again and again
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      armed_reg <= 1'b1;
    end else if (ctl_edge) begin
      armed_reg <= 1'b1;
    end else if (state_reg != EWAC_IDLE) begin
      armed_reg <= 1'b0;
    end
  end

  // =====================================================
  // operation state
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= EWAC_IDLE;
    end else if (!c.sel) begin
      state_reg <= EWAC_IDLE;
    end else begin
      unique case (state_reg)
        EWAC_IDLE: begin
          if (read_fire) begin
            state_reg <= EWAC_READ;
          end else if (armed_reg && mode == EWAC_MODE_ERASE) begin
            state_reg <= EWAC_ERASE;
          end else if (armed_reg && mode == EWAC_MODE_WRITE) begin
            state_reg <= EWAC_WRITE;
          end
        end
        EWAC_ERASE: begin
          if (mode != EWAC_MODE_ERASE) state_reg <= EWAC_IDLE;
        end
        EWAC_WRITE: begin
          if (mode != EWAC_MODE_WRITE) state_reg <= EWAC_IDLE;
        end
        EWAC_READ: begin
          // held until mode lines switch or deselect
          if (!c.mode_line_one || c.mode_line_two != prev_reg.mode_line_two) begin
            state_reg <= EWAC_IDLE;
          end
        end
      endcase
    end
  end

  // =====================================================
  // programming timer; it restarts whenever the mode is left
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
    end else if (state_reg == EWAC_ERASE || state_reg == EWAC_WRITE) begin
      if (!done) cnt_reg <= cnt_reg + 32'h1;
    end else begin
      cnt_reg <= '0;
    end
  end

  // =====================================================
  // word storage: one slice per word behind a full address decode
  // cells commit only after the full programming time; a short pulse changes nothing
  for (genvar w = 0; w < EWAC_WORDS; w++) begin : g_word
    logic [EWAC_DATA_W-1:0] word_reg;
    logic                   erased_reg;
    logic                   hit;
    assign hit       = (c.word_address == EWAC_ADDR_W'(w));
    assign word_q[w] = word_reg;

    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        word_reg <= EWAC_DATA_RST;
      end else if (erase_commit && hit) begin
        word_reg <= EWAC_DATA_RST;
      end else if (write_commit && hit && erased_reg) begin
        word_reg <= din;
      end
    end

    // a write only lands on a word that an erase has preconditioned
    always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
        erased_reg <= 1'b0;
      end else if (erase_commit && hit) begin
        erased_reg <= 1'b1;
      end else if (write_commit && hit) begin
        erased_reg <= 1'b0;
      end
    end
  end

  // =====================================================
  // outputs
  logic [EWAC_DATA_W-1:0] read_word;
  assign read_word = word_q[c.word_address];

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      data_lines_out <= EWAC_DATA_RST;
    end else if (read_fire) begin
      // erased words read back as zero; undefined to the host
      data_lines_out <= read_word;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      data_lines_oe <= '0;
    end else begin
      data_lines_oe <= {EWAC_DATA_W{c.sel && state_reg == EWAC_READ
                        && c.mode_line_one
                        && c.mode_line_two == prev_reg.mode_line_two}};
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state_reg == EWAC_ERASE) || (state_reg == EWAC_WRITE);
    end
  end

  // deselect floats the word lines and flags the reduced-power state
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      power_down <= 1'b1;
    end else begin
      power_down <= !c.sel;
    end
  end
endmodule : ewac_core
`default_nettype wire

// ===== verilog/ewac_pkg.sv
`default_nettype none
package ewac_pkg;
  // =====================================================
  // geometry
  localparam int unsigned EWAC_ADDR_W = 5;
  localparam int unsigned EWAC_DATA_W = 16;
  localparam int unsigned EWAC_WORDS  = 32;
  // =====================================================
  // timing: clock 40 MHz; erase/write minimum hold
  localparam int unsigned EWAC_CLK_HZ     = 40000000;
  localparam int unsigned EWAC_PROG_STD_MS = 50;
  localparam int unsigned EWAC_PROG_HR_MS  = 100;
  localparam int unsigned EWAC_PROG_STD_CYC = EWAC_PROG_STD_MS * (EWAC_CLK_HZ / 1000);
  // =====================================================
  // mode codes {mode_line_one, mode_line_two}
  localparam logic [1:0] EWAC_MODE_WRITE = 2'h0;
  localparam logic [1:0] EWAC_MODE_ERASE = 2'h1;
  localparam logic [2:0] EWAC_SYNC_RST   = 3'h0;
  localparam logic [15:0] EWAC_DATA_RST  = 16'h0000;

  typedef struct packed {
    logic                   sel;
    logic                   mode_line_one;
    logic                   mode_line_two;
    logic                   strobe;
    logic [EWAC_ADDR_W-1:0] word_address;
  } ewac_ctl_t;

  typedef enum logic [3:0] {
    EWAC_IDLE  = 4'h1,
    EWAC_ERASE = 4'h2,
    EWAC_WRITE = 4'h4,
    EWAC_READ  = 4'h8
  } ewac_state_t;
endpackage : ewac_pkg
`default_nettype wire

// ===== verilog/ewac_sync.sv
`timescale 1ns/1ps
`default_nettype none
module ewac_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         mclk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  import ewac_pkg::*;
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // a bit changes only once stages two and three agree
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q      <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          q[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule : ewac_sync
`default_nettype wire

// ===== bench/ewac_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ewac_checker #(
  parameter int unsigned PROG_CYC = 20
) (
  input wire logic                mclk,
  input wire logic                nrst,
  input wire ewac_pkg::ewac_ctl_t ctl,
  input wire logic [15:0]         data_lines_out,
  input wire logic [15:0]         data_lines_oe,
  input wire logic                busy,
  input wire logic                power_down
);
  import ewac_pkg::*;
  // ==========
  // pins pass a synchronizer, so causes lag by a few cycles
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  a_desel_float: assert property (
    $fell(ctl.sel) |-> ##[1:8] (data_lines_oe == '0 && power_down))
    else $error("pins driven after deselect");
  a_desel_idle: assert property (
    (!ctl.sel)[*8] |-> (data_lines_oe == '0 && !busy && power_down))
    else $error("activity while deselected");
  a_select_wake: assert property (
    $rose(ctl.sel) |-> ##[1:8] !power_down)
    else $error("power down kept after select");
  a_read_cause: assert property (
    $rose(data_lines_oe[0]) |-> (ctl.sel && ctl.mode_line_one))
    else $error("drive without read mode");
  a_read_hold: assert property (
    (ctl.sel && ctl.mode_line_one && !ctl.strobe && $stable(ctl.mode_line_two))[*8]
    ##0 data_lines_oe[0]
    |=> (data_lines_oe[0] && $stable(data_lines_out)))
    else $error("read word not held");
  a_prog_cause: assert property (
    $rose(busy) |-> ($past(ctl.sel, 5) && !$past(ctl.mode_line_one, 5)))
    else $error("program without its mode");
  a_prog_float: assert property (
    busy |-> data_lines_oe == '0)
    else $error("pins driven while programming");
  a_word_drive: assert property (
    data_lines_oe == '0 || data_lines_oe == '1)
    else $error("partial word driven");
endmodule : ewac_checker
bind ewac_core ewac_checker #(.PROG_CYC(PROG_CYC)) ewac_checker_i (.mclk(mclk), .nrst(nrst),
  .ctl(ctl), .data_lines_out(data_lines_out), .data_lines_oe(data_lines_oe), .busy(busy),
  .power_down(power_down));
`default_nettype wire

// ===== bench/ewac_host.sv
`timescale 1ns/1ps
`default_nettype none
module ewac_host (
  input  wire logic                mclk,
  output var  ewac_pkg::ewac_ctl_t c,
  output wire logic [15:0]         din,
  input  wire logic [15:0]         dout,
  input  wire logic [15:0]         oe
);
  import ewac_pkg::*;
  logic [15:0] hd = 16'h0000;
  logic        wr = 1'b0;
  logic        late = 1'b0;
  // ==========
  // released lines show the inverse of the last word, not a stale copy
  assign din = wr ? hd : ((oe & dout) | (~oe & ~hd));
  initial c = '0;
  task automatic prog(input logic s, input logic [1:0] m, input logic [4:0] a,
                      input logic [15:0] d, input int n);
    @(negedge mclk);
    c.sel = s;
    c.word_address = a;
    hd = d;
    {c.mode_line_one, c.mode_line_two} = m;
    wr = (m == EWAC_MODE_WRITE);
    repeat (n) @(negedge mclk);
    {c.mode_line_one, c.mode_line_two} = 2'h2;
    wr = 1'b0;
    repeat (6) @(negedge mclk);
  endtask : prog
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    int i;
    @(negedge mclk);
    c.sel = 1'b1;
    c.word_address = a;
    c.mode_line_one = 1'b1;
    c.mode_line_two = ~c.mode_line_two;
    repeat (8) @(negedge mclk);
    c.strobe = 1'b1;
    repeat (4) @(negedge mclk);
    c.strobe = 1'b0;
    for (i = 0; i < 20 && oe !== 16'hffff; i++) @(negedge mclk);
    late = (oe !== 16'hffff);
    d = dout;
  endtask : rd
  // a held read is repeated for a new address by a strobe pulse alone
  task automatic reread(input logic [4:0] a, output logic [15:0] d);
    @(negedge mclk);
    c.word_address = a;
    repeat (8) @(negedge mclk);
    c.strobe = 1'b1;
    repeat (4) @(negedge mclk);
    c.strobe = 1'b0;
    repeat (4) @(negedge mclk);
    d = dout;
  endtask : reread
  task automatic deselect;
    @(negedge mclk);
    c.sel = 1'b0;
  endtask : deselect
endmodule : ewac_host
`default_nettype wire

// ===== bench/ewac_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ewac_core_tb;
  import ewac_pkg::*;
  logic        mclk = 1'b0;
  logic        nrst = 1'b0;
  ewac_ctl_t   ctl;
  logic [15:0] din, dout, oe, rdv;
  logic        busy, power_down;
  int          fails = 0, checked = 0;
  always #12.5 mclk = ~mclk;
  ewac_host ewac_host_i (.mclk(mclk), .c(ctl), .din(din), .dout(dout), .oe(oe));
  ewac_core #(.PROG_CYC(20)) ewac_core_i (.mclk(mclk), .nrst(nrst), .ctl(ctl),
    .data_lines_in(din), .data_lines_out(dout), .data_lines_oe(oe), .busy(busy),
    .power_down(power_down));
  // ==========
  task automatic conclude;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp || ewac_host_i.late) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
    if (ewac_host_i.late) conclude();
  endtask : chk
  task automatic t_rw;
    logic [4:0] al [3] = '{5'h00, 5'h10, 5'h1f};
    for (int k = 0; k < 3; k++) begin
      ewac_host_i.prog(1'b1, EWAC_MODE_ERASE, al[k], 16'h0000, 30);
      ewac_host_i.prog(1'b1, EWAC_MODE_WRITE, al[k], {11'h000, al[k]} ^ 16'hc3a5, 30);
      ewac_host_i.rd(al[k], rdv);
      chk(rdv, {11'h000, al[k]} ^ 16'hc3a5);
    end
    ewac_host_i.rd(5'h00, rdv);
    chk(rdv, 16'hc3a5);
    $display("t_rw done");
  endtask : t_rw
  task automatic t_refuse;
    ewac_host_i.prog(1'b1, EWAC_MODE_WRITE, 5'h1f, 16'h1234, 30);
    ewac_host_i.rd(5'h1f, rdv);
    chk(rdv, 16'hc3ba);
    ewac_host_i.prog(1'b0, EWAC_MODE_ERASE, 5'h1f, 16'h0000, 30);
    ewac_host_i.rd(5'h1f, rdv);
    chk(rdv, 16'hc3ba);
    ewac_host_i.prog(1'b1, EWAC_MODE_ERASE, 5'h10, 16'h0000, 30);
    ewac_host_i.rd(5'h10, rdv);
    chk(rdv, 16'h0000);
    ewac_host_i.prog(1'b1, EWAC_MODE_WRITE, 5'h10, 16'hffff, 5);
    ewac_host_i.rd(5'h10, rdv);
    chk(rdv, 16'h0000);
    $display("t_refuse done");
  endtask : t_refuse
  task automatic t_busy;
    fork
      ewac_host_i.prog(1'b1, EWAC_MODE_ERASE, 5'h08, 16'h0000, 30);
      begin
        repeat (15) @(negedge mclk);
        chk({15'h0000, busy}, 16'h0001);
        chk({15'h0000, power_down}, 16'h0000);
      end
    join
    chk({15'h0000, busy}, 16'h0000);
    $display("t_busy done");
  endtask : t_busy
  task automatic t_hold;
    ewac_host_i.rd(5'h00, rdv);
    repeat (30) @(negedge mclk);
    chk(oe, 16'hffff);
    chk(dout, 16'hc3a5);
    ewac_host_i.reread(5'h1f, rdv);
    chk(rdv, 16'hc3ba);
    chk(oe, 16'hffff);
    ewac_host_i.deselect();
    repeat (10) @(negedge mclk);
    chk(oe, 16'h0000);
    chk({15'h0000, power_down}, 16'h0001);
    $display("t_hold done");
  endtask : t_hold
  initial begin
    repeat (5) @(negedge mclk);
    nrst = 1'b1;
    repeat (10) @(negedge mclk);
    t_rw();
    t_refuse();
    t_busy();
    t_hold();
    conclude();
  end
endmodule : ewac_core_tb
`default_nettype wire
